/* File: asr_consts.vh */
`ifndef ASR_CONSTS_VH
`define ASR_CONSTS_VH
// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define ASR_CLK_HZ 50000000
`define ASR_OSC_START_US 1000
`define ASR_SETTLE_US 24000
`define ASR_RATE_HZ 125
`define ASR_OSC_START_CYC ((`ASR_CLK_HZ / 1000000) * `ASR_OSC_START_US)
`define ASR_SETTLE_CYC ((`ASR_CLK_HZ / 1000000) * `ASR_SETTLE_US)
`define ASR_PERIOD_CYC (`ASR_CLK_HZ / `ASR_RATE_HZ)
`define ASR_UPDATE_GUARD_CYC 100
// ----------------------------------------
// Word layout
// ----------------------------------------
`define ASR_RESULT_W 16
`define ASR_WORD_W 24
`define ASR_CHECK_PATTERN 3'h5
// Part identifier: arbitrary value
`define ASR_PART_IDENT 2'h2
`define ASR_FIFO_DEPTH 16
`define ASR_FIFO_AW 4
`endif

/* File: asr_sync.v */
`timescale 1ns/100ps
`default_nettype none
module asr_sync (
  input wire clk_sys_i,
  input wire resetn_i,
  input wire async_i,
  output wire sync_o
);
  // ----------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------
  reg meta_q;
  reg sync_q;
  always @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end
  assign sync_o = sync_q;
endmodule // asr_sync
`default_nettype wire

/* File: asr_fifo.v */
`timescale 1ns/100ps
`default_nettype none
module asr_fifo #(
  parameter WIDTH = 17,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk_sys_i,
  input wire resetn_i,
  input wire flush_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  // ----------------------------------------
  // Flip-flop storage
  // ----------------------------------------
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  assign in_ready_o = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always @(posedge clk_sys_i)
  begin
    if (push)
      mem_q[wr_q] <= in_data_i;
  end
  always @(posedge clk_sys_i)
  begin
    if (!resetn_i || flush_i)
    begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // asr_fifo
`default_nettype wire

/* File: asr_readout.v */
`timescale 1ns/100ps
`include "asr_consts.vh"
`default_nettype none
module asr_readout #(
  parameter OSC_START_CYC = `ASR_OSC_START_CYC,
  parameter SETTLE_CYC = `ASR_SETTLE_CYC,
  parameter PERIOD_CYC = `ASR_PERIOD_CYC,
  parameter GUARD_CYC = `ASR_UPDATE_GUARD_CYC
) (
  input wire clk_sys_i,
  input wire resetn_i,
  input wire powerdown_reset_n_i,
  input wire sclk_i,
  input wire [15:0] sample_i,
  input wire sample_over_i,
  input wire sample_valid_i,
  output wire sample_ready_o,
  output reg dout_rdy_o,
  output reg dout_rdy_oe_o,
  output reg running_o,
  output reg overflow_o
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  wire pd_n_s;
  wire sclk_s;
  asr_sync u_sync_pd (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .async_i(powerdown_reset_n_i),
    .sync_o(pd_n_s)
  );
  asr_sync u_sync_sclk (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .async_i(sclk_i),
    .sync_o(sclk_s)
  );
  reg sclk_d1_q;
  wire sclk_fall = sclk_d1_q && !sclk_s;
  wire sclk_rise = !sclk_d1_q && sclk_s;
  wire active = resetn_i && pd_n_s;
  // ----------------------------------------
  // Sample FIFO
  // ----------------------------------------
  // Filter front end is modelled as a sample stream; fifo drained per conversion
  wire fifo_valid;
  wire fifo_ready;
  wire [16:0] fifo_data;
  wire take;
  reg sample_ready_q;
  asr_fifo #(
    .WIDTH(17),
    .DEPTH(`ASR_FIFO_DEPTH),
    .AW(`ASR_FIFO_AW)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .flush_i(!pd_n_s),
    .in_valid_i(sample_valid_i && sample_ready_q),
    .in_ready_o(fifo_ready),
    .in_data_i({sample_over_i, sample_i}),
    .out_valid_o(fifo_valid),
    .out_ready_i(take),
    .out_data_o(fifo_data)
  );
  // ----------------------------------------
  // Sample ready
  // ----------------------------------------
  // Ready is registered, so a mirror of the fill level looks one push ahead
  localparam [4:0] LVL_FULL = 5'h10;
  reg [4:0] lvl_q;
  reg [4:0] lvl_d;
  wire fifo_push = sample_valid_i && sample_ready_q && fifo_ready;
  always @*
  begin
    lvl_d = lvl_q;
    if (fifo_push && !take)
      lvl_d = lvl_q + 5'h1;
    else if (take && !fifo_push)
      lvl_d = lvl_q - 5'h1;
  end
  always @(posedge clk_sys_i)
  begin
    if (!resetn_i || !pd_n_s)
    begin
      lvl_q <= 5'h0;
      sample_ready_q <= 1'b0;
    end
    else
    begin
      lvl_q <= lvl_d;
      sample_ready_q <= (lvl_d < LVL_FULL);
    end
  end
  assign sample_ready_o = sample_ready_q;
  // ----------------------------------------
  // Conversion timer
  // ----------------------------------------
  localparam ST_OFF = 2'h0;
  localparam ST_OSC = 2'h1;
  localparam ST_SETTLE = 2'h2;
  localparam ST_RUN = 2'h3;
  reg [1:0] st_q;
  reg [1:0] st_d;
  reg [20:0] tmr_q;
  reg [20:0] tmr_d;
  wire conv_done = (st_q == ST_RUN || st_q == ST_SETTLE) && tmr_q == 21'h0;
  // Guard window before update: line forced high
  wire in_guard = (st_q == ST_RUN) && (tmr_q < GUARD_CYC[20:0]);
  assign take = conv_done && fifo_valid;
  always @*
  begin
    st_d = st_q;
    tmr_d = tmr_q;
    case (st_q)
      ST_OFF:
      begin
        st_d = ST_OSC;
        tmr_d = OSC_START_CYC[20:0] - 21'h1;
      end
      ST_OSC:
      begin
        if (tmr_q == 21'h0)
        begin
          st_d = ST_SETTLE;
          tmr_d = SETTLE_CYC[20:0] - 21'h1;
        end
        else
          tmr_d = tmr_q - 21'h1;
      end
      ST_SETTLE, ST_RUN:
      begin
        if (tmr_q == 21'h0)
        begin
          st_d = ST_RUN;
          tmr_d = PERIOD_CYC[20:0] - 21'h1;
        end
        else
          tmr_d = tmr_q - 21'h1;
      end
      default:
      begin
        st_d = ST_OFF;
        tmr_d = 21'h0;
      end
    endcase
  end
  // ----------------------------------------
  // Output word and shifter
  // ----------------------------------------
  reg [23:0] shift_q;
  reg [4:0] bits_q;
  reg avail_q;
  reg busy_q;
  wire [7:0] status;
  wire [23:0] word_next;
  localparam [4:0] WORD_BITS = 5'd24;
  // ----------------------------------------
  // Status byte
  // ----------------------------------------
  wire status_rdy_n = 1'b0;
  wire status_zero = 1'b0;
  wire status_err = fifo_data[16];
  wire [1:0] part_ident = `ASR_PART_IDENT;
  wire [2:0] check_pattern = `ASR_CHECK_PATTERN;
  wire part_ident_hi = part_ident[1];
  wire part_ident_lo = part_ident[0];
  wire check_pattern_b2 = check_pattern[2];
  wire check_pattern_b1 = check_pattern[1];
  wire check_pattern_b0 = check_pattern[0];
  assign status = {status_rdy_n, status_zero, status_err, part_ident_hi, part_ident_lo,
    check_pattern_b2, check_pattern_b1, check_pattern_b0};
  assign word_next = {fifo_data[15:0], status};
  // Half-read words count as unread: the host sees its pattern fail
  wire withdraw = avail_q && in_guard;
  wire last_bit = busy_q && sclk_rise && (bits_q == WORD_BITS);
  // ----------------------------------------
  // Serial clock edges
  // ----------------------------------------
  // Preset to idle high: no false edge on release
  always @(posedge clk_sys_i)
  begin
    if (!active)
      sclk_d1_q <= 1'b1;
    else
      sclk_d1_q <= sclk_s;
  end
  // ----------------------------------------
  // Timer registers
  // ----------------------------------------
  always @(posedge clk_sys_i)
  begin
    if (!active)
    begin
      st_q <= ST_OFF;
      tmr_q <= 21'h0;
    end
    else
    begin
      st_q <= st_d;
      tmr_q <= tmr_d;
    end
  end
  // ----------------------------------------
  // Phase and line enable
  // ----------------------------------------
  always @(posedge clk_sys_i)
  begin
    if (!active)
    begin
      running_o <= 1'b0;
      dout_rdy_oe_o <= 1'b0;
    end
    else
    begin
      // From next state: the flag rises with the first word
      running_o <= (st_d == ST_RUN);
      dout_rdy_oe_o <= 1'b1;
    end
  end
  // ----------------------------------------
  // Overflow flag
  // ----------------------------------------
  // Sticky until power-down; a starved filter leaves no word to offer
  always @(posedge clk_sys_i)
  begin
    if (!active)
      overflow_o <= 1'b0;
    else if (conv_done && !fifo_valid)
      overflow_o <= 1'b1;
  end
  // ----------------------------------------
  // Shifter and line
  // ----------------------------------------
  always @(posedge clk_sys_i)
  begin
    if (!active)
    begin
      shift_q <= 24'h0;
      bits_q <= 5'h0;
      avail_q <= 1'b0;
      busy_q <= 1'b0;
      dout_rdy_o <= 1'b1;
    end
    else if (conv_done)
    begin
      // Interface reset; aborts partial reads
      bits_q <= 5'h0;
      busy_q <= 1'b0;
      avail_q <= fifo_valid;
      dout_rdy_o <= !fifo_valid;
      if (fifo_valid)
        shift_q <= word_next;
    end
    else if (withdraw)
    begin
      avail_q <= 1'b0;
      busy_q <= 1'b0;
      bits_q <= 5'h0;
      dout_rdy_o <= 1'b1;
    end
    else if (avail_q && sclk_fall)
    begin
      busy_q <= 1'b1;
      dout_rdy_o <= shift_q[23];
      shift_q <= {shift_q[22:0], 1'b0};
      bits_q <= bits_q + 5'h1;
    end
    else if (last_bit)
    begin
      // Last bit sampled: word spent
      avail_q <= 1'b0;
      busy_q <= 1'b0;
      bits_q <= 5'h0;
      dout_rdy_o <= 1'b1;
    end
  end
endmodule // asr_readout
`default_nettype wire

/* File: asr_readout_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module asr_readout_checker (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic powerdown_reset_n_i,
  input wire logic sample_ready_o,
  input wire logic dout_rdy_o,
  input wire logic dout_rdy_oe_o,
  input wire logic running_o
);
  // ---
  // Power-down steps
  // ---
  default clocking
    @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);
  // Five cycles cover the pin synchroniser
  sequence s_pd_low;
    !powerdown_reset_n_i [*5];
  endsequence
  sequence s_pd_high;
    powerdown_reset_n_i [*5];
  endsequence
  chk_pd_tristate: assert property (s_pd_low |-> !dout_rdy_oe_o)
    else $error("line driven in power-down");
  chk_pd_ready: assert property (s_pd_low |-> !sample_ready_o)
    else $error("sample ready in power-down");
  chk_oe_release: assert property (s_pd_high |-> dout_rdy_oe_o)
    else $error("line not driven after release");
  chk_low_driven: assert property (!dout_rdy_o |-> dout_rdy_oe_o)
    else $error("low line not driven");
  chk_off_stopped: assert property (!dout_rdy_oe_o |-> !running_o)
    else $error("converting while off");
  chk_release_high: assert property ($rose(dout_rdy_oe_o) |-> dout_rdy_o [*8])
    else $error("line not high after release");
  chk_start_delay: assert property ($rose(powerdown_reset_n_i) |-> !running_o [*8])
    else $error("conversion before clock start");
  chk_fall_running: assert property ($fell(dout_rdy_o) |-> running_o)
    else $error("line low before settling");
endmodule // asr_readout_checker
bind asr_readout asr_readout_checker asr_readout_checker_inst (.clk_sys_i(clk_sys_i),
  .resetn_i(resetn_i), .powerdown_reset_n_i(powerdown_reset_n_i),
  .sample_ready_o(sample_ready_o), .dout_rdy_o(dout_rdy_o),
  .dout_rdy_oe_o(dout_rdy_oe_o), .running_o(running_o));
`default_nettype wire

/* File: asr_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module asr_host_model (
  input wire logic line_i,
  output logic sclk_o
);
  // ---
  // Host read
  // ---
  initial sclk_o = 1'h1;
  // A short count leaves an aborted frame
  task automatic read_word(input int nbits, output logic [23:0] w);
    w = 24'h000000;
    #13;
    repeat (nbits)
    begin
      #80 sclk_o = 1'h0;
      #80 sclk_o = 1'h1;
      w = {w[22:0], line_i};
    end
  endtask
endmodule // asr_host_model
`default_nettype wire

/* File: test_asr_readout.sv */
`timescale 1ns/100ps
`default_nettype none
`include "asr_consts.vh"
module test_asr_readout;
  logic clk_sys_i = 1'h0;
  logic resetn_i = 1'h0;
  logic pd = 1'h1;
  logic vld = 1'h0;
  logic ovr = 1'h0;
  logic last = 1'h1;
  logic [15:0] smp = 16'h0000;
  logic [23:0] w;
  wire logic sclk, rdy, dout, oe, run, ovf;
  wire logic line = oe ? dout : ~last;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  int t0, t1, n;
  always #10 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) cyc <= cyc + 1;
  // Released line must not keep its old level
  always @(posedge clk_sys_i)
    if (oe)
      last <= dout;
  asr_readout #(.OSC_START_CYC(20), .SETTLE_CYC(60), .PERIOD_CYC(400), .GUARD_CYC(5))
  asr_readout_inst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .powerdown_reset_n_i(pd),
    .sclk_i(sclk), .sample_i(smp), .sample_over_i(ovr), .sample_valid_i(vld),
    .sample_ready_o(rdy), .dout_rdy_o(dout), .dout_rdy_oe_o(oe), .running_o(run),
    .overflow_o(ovf));
  asr_host_model asr_host_model_inst (.line_i(line), .sclk_o(sclk));
  // ---
  // Helpers
  // ---
  task end_of_test;
    $display("Errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    compares++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %s exp %h got %h", nm, e, g);
    end
  endtask
  task tick(input int k);
    repeat (k) @(posedge clk_sys_i);
    #2;
  endtask
  task wait_line(input logic v);
    int i;
    for (i = 0; i < 900 && line !== v; i++)
      tick(1);
    chk("line wait", {23'h0, v}, {23'h0, line});
    if (line !== v)
      end_of_test;
  endtask
  task push(input logic [15:0] s, input logic o);
    int i;
    smp = s;
    ovr = o;
    vld = 1'h1;
    for (i = 0; i < 900 && rdy !== 1'h1; i++)
      tick(1);
    chk("push ready", 24'h000001, {23'h0, rdy});
    if (rdy !== 1'h1)
      end_of_test;
    tick(1);
    vld = 1'h0;
    tick(1);
  endtask
  // Read must start at once: the word only lives one period
  task read_chk(input logic [15:0] s, input logic o);
    wait_line(1'h0);
    t1 = cyc;
    asr_host_model_inst.read_word(24, w);
    chk("word", {s, 2'h0, o, `ASR_PART_IDENT, 3'h5}, w);
    tick(60);
    chk("line after read", 24'h000001, {23'h0, line});
  endtask
  // ---
  // Scenarios
  // ---
  task sc_codes;
    read_chk(16'h0000, 1'h0);
    push(16'h8000, 1'h0);
    read_chk(16'h8000, 1'h0);
    push(16'hFFFF, 1'h1);
    read_chk(16'hFFFF, 1'h1);
  endtask
  task sc_unread;
    push(16'h1234, 1'h0);
    push(16'h5678, 1'h0);
    wait_line(1'h0);
    t0 = cyc;
    wait_line(1'h1);
    chk("guard", 24'h000001, {23'h0, (cyc - t0) < 400 && (cyc - t0) >= 390});
    read_chk(16'h5678, 1'h0);
    chk("period", 24'h000190, 24'(t1 - t0));
  endtask
  task sc_abort;
    push(16'hA5A5, 1'h0);
    push(16'h3C3C, 1'h0);
    wait_line(1'h0);
    asr_host_model_inst.read_word(10, w);
    wait_line(1'h1);
    read_chk(16'h3C3C, 1'h0);
  endtask
  task sc_fill;
    vld = 1'h1;
    for (n = 0; n < 20 && rdy === 1'h1; n++)
    begin
      smp = 16'h0100 + n[15:0];
      tick(1);
    end
    chk("fill refused", 24'h000000, {23'h0, rdy});
    chk("fill count", 24'h000010, 24'(n));
    vld = 1'h0;
    for (n = 0; n < 16; n++)
      read_chk(16'h0100 + n[15:0], 1'h0);
    tick(450);
    chk("empty line", 24'h000001, {23'h0, line});
    chk("overflow", 24'h000001, {23'h0, ovf});
  endtask
  task sc_pd;
    pd = 1'h0;
    tick(5);
    chk("pd enable", 24'h000000, {23'h0, oe});
    chk("pd ready", 24'h000000, {23'h0, rdy});
    chk("pd running", 24'h000000, {23'h0, run});
    pd = 1'h1;
    tick(4);
    chk("release line", 24'h000003, {22'h0, oe, line});
    chk("overflow cleared", 24'h000000, {23'h0, ovf});
    t0 = cyc;
    push(16'h4321, 1'h1);
    read_chk(16'h4321, 1'h1);
    chk("running", 24'h000001, {23'h0, run});
    chk("settle", 24'h000001, {23'h0, (t1 - t0) >= 74 && (t1 - t0) <= 86});
  endtask
  initial
  begin
    tick(4);
    resetn_i = 1'h1;
    push(16'h0000, 1'h0);
    sc_codes;
    sc_unread;
    sc_abort;
    sc_fill;
    sc_pd;
    end_of_test;
  end
endmodule // test_asr_readout
`default_nettype wire
